/* File: logic/coupler_status_pkg.sv */
// constants for the coupler status read/write command interpreter
// assumes a byte-level link engine delivers received bytes and takes bytes
// Operation
// - After the control byte the device returns a status info byte.
// - Then the device sends a confirmation byte equal to the info byte.
// - At power-on: auto mode, control output tied to the main output.
// - Control byte bit 6 picks the association: one auxiliary, zero main.
// - Control byte bit 5 picks the mode: one manual, zero auto.
// - In manual mode control bit 7 drives the transistor; else ignored.
// - Settings change only when control byte bits 3 and 4 are both zero.
// - The info byte shows the settings after the current control byte.
// - Info bits 0..3 are main active, main level, aux active, aux level.
// - An inactive output flags its own falling edges in bits 4 and 5.
// - Event flags stay set until the all-lines-off command clears them.
// - Info bit 7 shows the mode: zero auto, one manual.
// - Info bit 6 is the association in auto, the drive in manual.
// - A line level is meaningful only while its output is inactive.
package coupler_status_pkg;
    localparam logic [7:0] CMD_STATUS_RW  = 8'h5A;
    // control byte fields
    localparam int CTL_DRIVE_BIT   = 7;
    localparam int CTL_ASSOC_BIT   = 6;
    localparam int CTL_MODE_BIT    = 5;
    localparam int CTL_LOCK_HI_BIT = 4;
    localparam int CTL_LOCK_LO_BIT = 3;
    // info byte fields
    localparam int INFO_MAIN_STAT  = 0;
    localparam int INFO_MAIN_LEVEL = 1;
    localparam int INFO_AUX_STAT   = 2;
    localparam int INFO_AUX_LEVEL  = 3;
    localparam int INFO_MAIN_EVT   = 4;
    localparam int INFO_AUX_EVT    = 5;
    localparam int INFO_CTL_REPORT = 6;
    localparam int INFO_MODE       = 7;
    // reset values
    localparam logic MODE_RESET    = 1'b0; // auto-control
    localparam logic ASSOC_RESET   = 1'b0; // main output
    localparam logic DRIVE_RESET   = 1'b0; // transistor off
    localparam logic [7:0] BYTE_RESET = 8'h00;

    typedef enum logic [1:0] {
        ST_IDLE     = 2'b00,
        ST_WAIT_CTL = 2'b01,
        ST_SEND_INF = 2'b10,
        ST_SEND_CNF = 2'b11
    } seq_state_t;
endpackage

/* File: logic/edge_event_flag.sv */
// sticky falling-edge flag for one coupler output
// assumes line level and active state are synchronous to ref_clk
`timescale 1ns/1ps
module edge_event_flag
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic reset,
    // line
    input  wire logic line_level,
    input  wire logic output_active,
    input  wire logic clear_flags,
    // result
    output logic      falling_edge_flag
);
    logic level_reg;
    logic set_evt;

    // a falling edge while the output is inactive
    assign set_evt = !output_active && level_reg && !line_level;

    // set wins over a clear in the same cycle
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            level_reg         <= 1'b1;
            falling_edge_flag <= 1'b0;
        end
        else
        begin
            level_reg <= line_level;
            if (set_evt)
                falling_edge_flag <= 1'b1;
            else if (clear_flags)
                falling_edge_flag <= 1'b0;
        end
    end

    // checks
    chk_edge_sets_flag: assert property (
        @(posedge ref_clk) disable iff (reset)
        set_evt |=> falling_edge_flag)
        else $error("falling edge on inactive output not flagged");
    chk_flag_holds: assert property (
        @(posedge ref_clk) disable iff (reset)
        falling_edge_flag && !clear_flags |=> falling_edge_flag)
        else $error("event flag dropped without all-lines-off");
    chk_flag_clears: assert property (
        @(posedge ref_clk) disable iff (reset)
        clear_flags && !set_evt |=> !falling_edge_flag)
        else $error("event flag not cleared by all-lines-off");
endmodule // edge_event_flag

/* File: logic/coupler_status_rw.sv */
// status read/write command interpreter of the network coupler
// assumes a link engine passes whole bytes in and takes whole bytes out
`timescale 1ns/1ps
module coupler_status_rw
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // received bytes
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        bus_reset,
    // transmitted bytes
    output logic             tx_valid,
    output logic [7:0]       tx_data,
    input  wire logic        tx_ready,
    // coupler state from the switching logic
    input  wire logic        main_active,
    input  wire logic        aux_active,
    input  wire logic        main_line,
    input  wire logic        aux_line,
    input  wire logic        lines_off,
    // settings and control output
    output logic             mode_manual,
    output logic             assoc_aux,
    output logic             ctl_out_drive,
    output logic             main_evt,
    output logic             aux_evt
);
    import coupler_status_pkg::*;

    seq_state_t state_reg;
    seq_state_t state_next;
    logic       manual_val_reg;
    logic       accept;
    logic       ctl_seen;
    logic       mode_next;
    logic       assoc_next;
    logic       manual_next;
    logic       drive_next;
    logic       report_next;
    logic       tx_done;
    logic [7:0] info_next;

    // decode of the control byte; bits 0..2 never looked at
    assign ctl_seen = (state_reg == ST_WAIT_CTL) && rx_valid;
    assign accept = ctl_seen && !rx_data[CTL_LOCK_HI_BIT]
                    && !rx_data[CTL_LOCK_LO_BIT];
    assign mode_next   = accept ? rx_data[CTL_MODE_BIT] : mode_manual;
    assign assoc_next  = accept ? rx_data[CTL_ASSOC_BIT] : assoc_aux;
    // manual drive value only taken while manual mode is chosen
    assign manual_next = (accept && rx_data[CTL_MODE_BIT]) ?
                         rx_data[CTL_DRIVE_BIT] : manual_val_reg;
    assign drive_next  = mode_next ? manual_next
                         : (assoc_next ? aux_active : main_active);
    assign report_next = mode_next ? manual_next : assoc_next;
    assign tx_done     = tx_valid && tx_ready;

    // info byte from the settings now in force; stat bit 0 means active
    // level bits are passed as sensed, valid only while inactive
    assign info_next = {mode_next, report_next, aux_evt, main_evt,
                        aux_line, !aux_active,
                        main_line, !main_active};

    // command sequence
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
                if (rx_valid && rx_data == CMD_STATUS_RW)
                    state_next = ST_WAIT_CTL;
            ST_WAIT_CTL:
                if (rx_valid)
                    state_next = ST_SEND_INF;
            ST_SEND_INF:
                if (tx_done)
                    state_next = ST_SEND_CNF;
            ST_SEND_CNF:
                if (tx_done)
                    state_next = ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
        if (bus_reset)
            state_next = ST_IDLE;
    end

    // state and settings registers, defaults at power-on
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            state_reg      <= ST_IDLE;
            mode_manual    <= MODE_RESET;
            assoc_aux      <= ASSOC_RESET;
            manual_val_reg <= DRIVE_RESET;
            ctl_out_drive  <= DRIVE_RESET;
        end
        else
        begin
            state_reg      <= state_next;
            mode_manual    <= mode_next;
            assoc_aux      <= assoc_next;
            manual_val_reg <= manual_next;
            ctl_out_drive  <= drive_next;
        end
    end

    // byte out: info then the same byte again as confirmation
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            tx_valid <= 1'b0;
            tx_data  <= BYTE_RESET;
        end
        else if (bus_reset)
            tx_valid <= 1'b0;
        else if (ctl_seen)
        begin
            tx_valid <= 1'b1;
            tx_data  <= info_next;
        end
        else if (tx_done && state_reg == ST_SEND_CNF)
            tx_valid <= 1'b0; // tx_data kept: confirmation equals info
    end

    // event flags per output
    edge_event_flag main_flag
    (
        .ref_clk           (ref_clk),
        .reset             (reset),
        .line_level        (main_line),
        .output_active     (main_active),
        .clear_flags       (lines_off),
        .falling_edge_flag (main_evt)
    );

    edge_event_flag aux_flag
    (
        .ref_clk           (ref_clk),
        .reset             (reset),
        .line_level        (aux_line),
        .output_active     (aux_active),
        .clear_flags       (lines_off),
        .falling_edge_flag (aux_evt)
    );

    // checks of the reply sequence
    chk_info_follows_ctl: assert property (
        @(posedge ref_clk) disable iff (reset || bus_reset)
        ctl_seen |=> tx_valid)
        else $error("no info byte after control byte");
    chk_reply_held: assert property (
        @(posedge ref_clk) disable iff (reset || bus_reset)
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply byte changed before it was taken");
    chk_confirm_equals_info: assert property (
        @(posedge ref_clk) disable iff (reset || bus_reset)
        (state_reg == ST_SEND_INF && tx_done)
        |=> tx_valid && tx_data == $past(tx_data))
        else $error("confirmation differs from info byte");
    chk_confirm_ends: assert property (
        @(posedge ref_clk) disable iff (reset)
        (state_reg == ST_SEND_CNF && tx_done) |=> !tx_valid)
        else $error("reply strobe stays up after confirmation");
    chk_abort_idle: assert property (
        @(posedge ref_clk) disable iff (reset)
        bus_reset |=> !tx_valid && state_reg == ST_IDLE)
        else $error("link reset did not abort the command");

    // checks of the settings
    chk_power_on_default: assert property (
        @(posedge ref_clk) disable iff (reset)
        $past(reset) |-> !mode_manual && !assoc_aux)
        else $error("power-on settings wrong");
    chk_assoc_taken: assert property (
        @(posedge ref_clk) disable iff (reset)
        accept |=> assoc_aux == $past(rx_data[CTL_ASSOC_BIT]))
        else $error("association not taken");
    chk_auto_follows: assert property (
        @(posedge ref_clk) disable iff (reset)
        !mode_next |=> ctl_out_drive
        == (assoc_aux ? $past(aux_active) : $past(main_active)))
        else $error("auto drive does not follow associated output");
    chk_mode_taken: assert property (
        @(posedge ref_clk) disable iff (reset)
        accept |=> mode_manual == $past(rx_data[CTL_MODE_BIT]))
        else $error("mode not taken");
    chk_manual_drive: assert property (
        @(posedge ref_clk) disable iff (reset)
        accept && rx_data[CTL_MODE_BIT]
        |=> ctl_out_drive == $past(rx_data[CTL_DRIVE_BIT]))
        else $error("manual drive value not applied");
    chk_drive_kept: assert property (
        @(posedge ref_clk) disable iff (reset)
        accept && !rx_data[CTL_MODE_BIT] |=> $stable(manual_val_reg))
        else $error("drive value taken in auto mode");
    chk_locked_settings: assert property (
        @(posedge ref_clk) disable iff (reset)
        ctl_seen && (rx_data[CTL_LOCK_HI_BIT] || rx_data[CTL_LOCK_LO_BIT])
        |=> $stable(mode_manual) && $stable(assoc_aux))
        else $error("settings changed while locked");

    // checks of the info byte fields
    chk_info_mode_bit: assert property (
        @(posedge ref_clk) disable iff (reset || bus_reset)
        ctl_seen |=> tx_data[INFO_MODE] == mode_manual
        && tx_data[INFO_CTL_REPORT]
        == (mode_manual ? ctl_out_drive : assoc_aux))
        else $error("info byte mode or report bit wrong");
    chk_info_stat_bits: assert property (
        @(posedge ref_clk) disable iff (reset || bus_reset)
        ctl_seen |=> tx_data[INFO_MAIN_STAT] == !$past(main_active)
        && tx_data[INFO_AUX_STAT] == !$past(aux_active))
        else $error("info byte active bits wrong");
    chk_info_level_bits: assert property (
        @(posedge ref_clk) disable iff (reset || bus_reset)
        ctl_seen |=> tx_data[INFO_MAIN_LEVEL] == $past(main_line)
        && tx_data[INFO_AUX_LEVEL] == $past(aux_line))
        else $error("info byte level bits wrong");
    chk_info_event_bits: assert property (
        @(posedge ref_clk) disable iff (reset || bus_reset)
        ctl_seen |=> tx_data[INFO_MAIN_EVT] == $past(main_evt)
        && tx_data[INFO_AUX_EVT] == $past(aux_evt))
        else $error("info byte event bits wrong");

    // covers of the main exchanges
    cov_locked_write: cover property (@(posedge ref_clk) ctl_seen && !accept);
    cov_manual_on: cover property (@(posedge ref_clk)
        accept && rx_data[CTL_MODE_BIT] && rx_data[CTL_DRIVE_BIT]);
    cov_full_exchange: cover property (@(posedge ref_clk)
        state_reg == ST_SEND_CNF && tx_done);
    cov_abort_wait: cover property (@(posedge ref_clk)
        bus_reset && state_reg == ST_WAIT_CTL);
    cov_flags_cleared: cover property (@(posedge ref_clk)
        lines_off && (main_evt || aux_evt));
endmodule // coupler_status_rw

/* File: testbench/link_master.sv */
// bus master model: sends command and control bytes, reads two replies
// assumes the interpreter samples its inputs on the rising edge
`timescale 1ns/1ps
module link_master
(
    // clock
    input  wire logic       ref_clk,
    // toward the interpreter
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            tx_ready,
    // from the interpreter
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data
);
    import coupler_status_pkg::*;
    // idle master
    initial
    begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        tx_ready = 1'b0;
    end
    // one byte strobe; a released data line does not keep its value
    task automatic send(input logic [7:0] b);
        @(negedge ref_clk);
        rx_valid = 1'b1;
        rx_data  = b;
        @(negedge ref_clk);
        rx_valid = 1'b0;
        rx_data  = ~b;
    endtask
    // full command: code, control byte, stall, then two reads
    task automatic xfer(input logic [7:0] ctl, input int stall,
                        output logic [7:0] r0, output logic [7:0] r1);
        int n;
        n  = 0;
        r0 = 8'hxx;
        r1 = 8'hxx;
        send(CMD_STATUS_RW);
        send(ctl);
        repeat (stall) @(negedge ref_clk);
        tx_ready = 1'b1;
        for (int i = 0; i < 8 && n < 2; i++)
        begin
            if (tx_valid && tx_ready)
            begin
                if (n == 0)
                    r0 = tx_data;
                else
                    r1 = tx_data;
                n++;
            end
            @(negedge ref_clk);
        end
        tx_ready = 1'b0;
    endtask
endmodule // link_master

/* File: testbench/tb.sv */
// self-checking bench for the status read/write interpreter
// assumes the master model of link_master.sv
`timescale 1ns/1ps
module tb;
    import coupler_status_pkg::*;
    logic       ref_clk = 1'b0;
    logic       reset = 1'b1;
    logic       bus_reset = 1'b0;
    logic       main_active = 1'b0;
    logic       aux_active = 1'b0;
    logic       main_line = 1'b1;
    logic       aux_line = 1'b1;
    logic       lines_off = 1'b0;
    logic       rx_valid, tx_valid, tx_ready;
    logic [7:0] rx_data, tx_data, b0, b1;
    logic       mode_manual, assoc_aux, ctl_out_drive, main_evt, aux_evt;
    logic       mode_m, assoc_m, drv_m, mev_m, aev_m;
    logic [7:0] state_seen;
    int         n_errors = 0;
    int         compares = 0;
    // clock
    always #5 ref_clk = ~ref_clk;
    // design and master
    coupler_status_rw i_dut (.ref_clk(ref_clk), .reset(reset),
        .rx_valid(rx_valid), .rx_data(rx_data), .bus_reset(bus_reset),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .main_active(main_active), .aux_active(aux_active),
        .main_line(main_line), .aux_line(aux_line), .lines_off(lines_off),
        .mode_manual(mode_manual), .assoc_aux(assoc_aux),
        .ctl_out_drive(ctl_out_drive), .main_evt(main_evt),
        .aux_evt(aux_evt));
    link_master i_master (.ref_clk(ref_clk), .rx_valid(rx_valid),
        .rx_data(rx_data), .tx_ready(tx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data));
    // observed reply strobe, settings and flags in one word
    assign state_seen = {2'h0, tx_valid, mode_manual, assoc_aux,
                         ctl_out_drive, main_evt, aux_evt};
    task automatic chk(input string what, input logic [7:0] exp, got);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [7:0] info_exp();
        return {mode_m, mode_m ? drv_m : assoc_m, aev_m, mev_m,
                aux_line, ~aux_active, main_line, ~main_active};
    endfunction
    // expected strobe (idle), settings and flags; auto drive follows output
    function automatic logic [7:0] state_exp();
        logic d;
        d = mode_m ? drv_m : (assoc_m ? aux_active : main_active);
        return {3'h0, mode_m, assoc_m, d, mev_m, aev_m};
    endfunction
    // one command with model update and checks of both replies
    task automatic run_cmd(input logic [7:0] c, input int stall);
        if (c[4:3] == 2'b00)
        begin
            mode_m  = c[5];
            assoc_m = c[6];
            if (c[5])
                drv_m = c[7];
        end
        i_master.xfer(c, stall, b0, b1);
        chk("info", info_exp(), b0);
        chk("confirm", info_exp(), b1);
        chk("settings", state_exp(), state_seen);
    endtask
    // control bytes: association, mode, drive, locks, ignored low bits
    task automatic t_settings();
        logic [7:0] tbl [8] = '{8'h40, 8'hA7, 8'h58, 8'h20,
                                8'hF0, 8'hC8, 8'h80, 8'h47};
        @(negedge ref_clk);
        aux_active = 1'b1;
        foreach (tbl[i])
            run_cmd(tbl[i], i % 3);
    endtask
    // falling edges on inactive and active outputs, then clearing
    task automatic t_events();
        @(negedge ref_clk);
        main_line = 1'b0;
        repeat (2) @(negedge ref_clk);
        mev_m = 1'b1;
        chk("flags", state_exp(), state_seen);
        main_line = 1'b1;
        aux_line  = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk("flags held", state_exp(), state_seen);
        run_cmd(8'h18, 1);
        lines_off = 1'b1;
        @(negedge ref_clk);
        lines_off = 1'b0;
        @(negedge ref_clk);
        mev_m = 1'b0;
        chk("flags cleared", state_exp(), state_seen);
    endtask
    // abort after the command code, then a clean command
    task automatic t_abort();
        i_master.send(CMD_STATUS_RW);
        bus_reset = 1'b1;
        @(negedge ref_clk);
        bus_reset = 1'b0;
        i_master.send(8'h20);
        repeat (3) @(negedge ref_clk);
        chk("abort", state_exp(), state_seen);
        run_cmd(8'h20, 2);
    endtask
    task automatic summarize();
        if (n_errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // main sequence
    initial
    begin
        {mode_m, assoc_m, drv_m, mev_m, aev_m} = 5'h00;
        repeat (12) @(negedge ref_clk);
        reset = 1'b0;
        chk("reset", state_exp(), state_seen);
        t_settings();
        t_events();
        t_abort();
        summarize();
    end
    // watchdog
    initial
    begin
        repeat (3000) @(posedge ref_clk);
        n_errors++;
        summarize();
    end
endmodule // tb
